// [rtl/irq_mask_params.svh]
// Offsets, field positions and reset values of the peripheral interrupt mask block
`ifndef IRQ_MASK_PARAMS_SVH
`define IRQ_MASK_PARAMS_SVH

// Byte offsets of the registers on the bus
`define CTRL_REG_OFS 8'h00
`define FLAG_REG_OFS 8'h04
`define MASK_REG_OFS 8'h8C
// Any access above the low 256 bytes is steered here, where nothing lives
`define UNMAPPED_OFS 8'hFF

// Core interrupt control fields
`define GLOBAL_EN_BIT 7
`define GROUP_EN_BIT 6

// Per-source fields, shared by the mask and the flag register
`define RECEIVE_BIT 5
`define TRANSMIT_BIT 4
`define SERIAL_BIT 3
`define CAPCMP_BIT 2
`define PERIOD_BIT 1
`define OVERFLOW_BIT 0

// Implemented bits of the mask register for each variant
`define MASK_IMPL_USART 8'hFF
`define MASK_IMPL_PLAIN 8'hCF
// Implemented flag bits for each variant
`define FLAG_IMPL_USART 6'h3F
`define FLAG_IMPL_PLAIN 6'h0F

// Reset values
`define CTRL_RESET 2'h0
`define MASK_RESET 8'h00
`define FLAG_RESET 1'b0

`endif

// [rtl/irq_mask_pkg.sv]
// Types shared by the peripheral interrupt mask block
package irq_mask_pkg;

   // One bit per peripheral source, bit 5 down to bit 0
   typedef struct packed {
      logic receive_irq;
      logic transmit_irq;
      logic sync_serial_irq;
      logic capture_compare_irq;
      logic period_match_irq;
      logic wide_timer_overflow_irq;
   } src_vec_t;

   // Register write strobe with its byte of data
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;

   // Register read request, held for the one wait cycle
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
   } reg_read_t;

endpackage

// [rtl/ahb_reg_port.sv]
// AHB-Lite slave front end: address capture, write strobe and registered read data
`timescale 1ns/100ps
module ahb_reg_port (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output irq_mask_pkg::reg_write_t wr,
   output irq_mask_pkg::reg_read_t rd,
   input wire logic [7:0] rd_data
);
   import irq_mask_pkg::*;
   `include "irq_mask_params.svh"

   logic wr_pend;
   logic rd_pend;
   logic [7:0] dph_addr;
   wire take = hsel & htrans[1] & hready;
   wire in_range = (haddr[31:8] == 24'h000000);
   wire [7:0] take_addr = in_range ? haddr[7:0] : `UNMAPPED_OFS;

   // Writes take no wait; reads take one so that read data leave a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dph_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend <= take & hwrite;
         rd_pend <= take & ~hwrite;
         if (take) begin
            dph_addr <= take_addr;
         end
         hreadyout <= ~(take & ~hwrite);
         hresp <= 1'b0; // Always OKAY
         if (rd_pend) begin
            hrdata <= {24'h000000, rd_data};
         end
      end
   end

   // Data phase strobes towards the register file
   assign wr = '{valid: wr_pend, addr: dph_addr, data: hwdata[7:0]};
   assign rd = '{valid: rd_pend, addr: dph_addr};
endmodule

// [rtl/event_flag_bank.sv]
// Sticky per-source event flags, cleared by writing one, with set winning over clear
`timescale 1ns/100ps
module event_flag_bank (
   input wire logic hclk,
   input wire logic hresetn,
   input irq_mask_pkg::src_vec_t events,
   input wire logic [5:0] clear,
   input wire logic [5:0] implemented,
   output logic [5:0] flags
);
   import irq_mask_pkg::*;
   `include "irq_mask_params.svh"

   wire [5:0] ev = events;

   // One flag per source; an event in the clearing cycle is kept
   for (genvar i = 0; i < 6; i++) begin : g_flag
      logic bit_q;
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            bit_q <= `FLAG_RESET;
         end else begin
            bit_q <= implemented[i] & (ev[i] | (bit_q & ~clear[i]));
         end
      end
      assign flags[i] = bit_q;
   end
endmodule

// [rtl/peripheral_irq_enable_mask.sv]
// Peripheral interrupt enable mask with group and global gating, on AHB-Lite
//
// Function
// - Each peripheral source has its own enable bit; only enabled sources interrupt.
// - Nothing reaches the core unless the peripheral group enable is set.
// - Bit 3 enables the synchronous serial port interrupt; zero blocks it.
// - Bit 2 enables the capture/compare unit interrupt; zero masks it.
// - Bit 1 enables the timer-two period match interrupt; zero masks it.
// - Bit 0 enables the sixteen-bit timer overflow interrupt; zero masks it.
// - With a USART, bit 5 enables its receive interrupt; zero masks it.
// - With a USART, bit 4 enables its transmit interrupt; zero masks it.
// - Flags set on their event whatever the individual, group or global enables hold.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
module peripheral_irq_enable_mask #(
   parameter bit has_usart = 1'b1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input irq_mask_pkg::src_vec_t irq_sources,
   output logic irq
);
   import irq_mask_pkg::*;
   `include "irq_mask_params.svh"

   reg_write_t wr;
   reg_read_t rd;
   logic [7:0] rd_data;
   logic global_irq_enable;
   logic peripheral_group_enable;
   logic [7:0] peripheral_irq_mask_reg;
   logic [5:0] flags;

   // Bus slave; only word transfers are issued, so the size is not decoded
   ahb_reg_port u_port (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .wr(wr),
      .rd(rd),
      .rd_data(rd_data)
   );

   // Variant selection: unimplemented bits are never stored
   wire [7:0] mask_impl = has_usart ? `MASK_IMPL_USART : `MASK_IMPL_PLAIN;
   wire [5:0] flag_impl = has_usart ? `FLAG_IMPL_USART : `FLAG_IMPL_PLAIN;

   // Address decode of the write strobe
   wire wr_ctrl = wr.valid && (wr.addr == `CTRL_REG_OFS);
   wire wr_flag = wr.valid && (wr.addr == `FLAG_REG_OFS);
   wire wr_mask = wr.valid && (wr.addr == `MASK_REG_OFS);

   // Write-one-to-clear on the flag register
   wire [5:0] flag_clear = wr_flag ? wr.data[5:0] : 6'h00;

   // Sticky flags follow the events alone, untouched by any enable
   event_flag_bank u_flags (
      .hclk(hclk),
      .hresetn(hresetn),
      .events(irq_sources),
      .clear(flag_clear),
      .implemented(flag_impl),
      .flags(flags)
   );

   // Next values of the control and mask registers
   wire next_global = wr_ctrl ? wr.data[`GLOBAL_EN_BIT] : global_irq_enable;
   wire next_group = wr_ctrl ? wr.data[`GROUP_EN_BIT] : peripheral_group_enable;
   wire [7:0] next_mask = wr_mask ? (wr.data & mask_impl) : peripheral_irq_mask_reg;

   // Control and mask storage; every enable starts cleared
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {global_irq_enable, peripheral_group_enable} <= `CTRL_RESET;
         peripheral_irq_mask_reg <= `MASK_RESET;
      end else begin
         global_irq_enable <= next_global;
         peripheral_group_enable <= next_group;
         peripheral_irq_mask_reg <= next_mask;
      end
   end

   // Per-source enable fields, named for the gating below
   wire receive_irq_en = peripheral_irq_mask_reg[`RECEIVE_BIT];
   wire transmit_irq_en = peripheral_irq_mask_reg[`TRANSMIT_BIT];
   wire sync_serial_irq_en = peripheral_irq_mask_reg[`SERIAL_BIT];
   wire capture_compare_irq_en = peripheral_irq_mask_reg[`CAPCMP_BIT];
   wire period_match_irq_en = peripheral_irq_mask_reg[`PERIOD_BIT];
   wire wide_timer_overflow_irq_en = peripheral_irq_mask_reg[`OVERFLOW_BIT];

   // Each flag passes only through its own enable bit
   wire [5:0] src_enabled = {
      receive_irq_en & flags[`RECEIVE_BIT],
      transmit_irq_en & flags[`TRANSMIT_BIT],
      sync_serial_irq_en & flags[`SERIAL_BIT],
      capture_compare_irq_en & flags[`CAPCMP_BIT],
      period_match_irq_en & flags[`PERIOD_BIT],
      wide_timer_overflow_irq_en & flags[`OVERFLOW_BIT]
   };

   // Group enable gates all peripheral sources, global enable gates the core
   wire next_irq = global_irq_enable & peripheral_group_enable & (|src_enabled);

   // Registered so the output leaves a flop; costs one cycle of latency
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // Read back; reserved control bits and unmapped offsets read as zero
   wire [7:0] ctrl_view = {global_irq_enable, peripheral_group_enable, 6'h00};
   wire [7:0] flag_view = {2'h0, flags};
   wire [7:0] mask_view = peripheral_irq_mask_reg;
   assign rd_data = (rd.addr == `CTRL_REG_OFS) ? ctrl_view :
                    (rd.addr == `FLAG_REG_OFS) ? flag_view :
                    (rd.addr == `MASK_REG_OFS) ? mask_view : 8'h00;

   // Helper: request accepted in an address phase
   wire take_rd = hsel & htrans[1] & hready & ~hwrite;
   wire take_wr = hsel & htrans[1] & hready & hwrite;
   wire [5:0] ev_vec = irq_sources;
   wire gates_open = global_irq_enable & peripheral_group_enable;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // An interrupt always traces back to an enabled, flagged source
   chk_irq_needs_enable: assert property (
      irq |-> $past(|(flags & peripheral_irq_mask_reg[5:0])))
      else $error("irq without an enabled pending source");

   // A closed group enable keeps the output low one cycle later
   chk_group_gate: assert property (
      !peripheral_group_enable |=> !irq)
      else $error("irq raised while group enable was clear");

   // Serial port source alone raises the output when enabled
   chk_serial_enable: assert property (
      (gates_open && flags[`SERIAL_BIT] && sync_serial_irq_en) |=> irq)
      else $error("enabled serial port flag did not interrupt");

   // Capture/compare source alone raises the output when enabled
   chk_capcmp_enable: assert property (
      (gates_open && flags[`CAPCMP_BIT] && capture_compare_irq_en) |=> irq)
      else $error("enabled capture/compare flag did not interrupt");

   // Period match source alone raises the output when enabled
   chk_period_enable: assert property (
      (gates_open && flags[`PERIOD_BIT] && period_match_irq_en) |=> irq)
      else $error("enabled period match flag did not interrupt");

   // Overflow source alone raises the output when enabled
   chk_overflow_enable: assert property (
      (gates_open && flags[`OVERFLOW_BIT] && wide_timer_overflow_irq_en) |=> irq)
      else $error("enabled overflow flag did not interrupt");

   // Receive event with its enable reaches the output two cycles on
   chk_receive_path: assert property (
      (has_usart && gates_open && receive_irq_en && ev_vec[`RECEIVE_BIT]
       && !wr.valid) |=> ##1 irq)
      else $error("enabled receive event did not interrupt");

   // Transmit flag with its enable clear never contributes alone
   chk_transmit_mask: assert property (
      (flags[`TRANSMIT_BIT] && !transmit_irq_en && ((src_enabled & 6'h2F) == 6'h00))
      |=> !irq)
      else $error("masked transmit source raised irq");

   // Transmit flag raises the output when enabled
   chk_transmit_enable: assert property (
      (gates_open && flags[`TRANSMIT_BIT] && transmit_irq_en) |=> irq)
      else $error("enabled transmit flag did not interrupt");

   // Receive flag raises the output when enabled
   chk_receive_enable: assert property (
      (gates_open && flags[`RECEIVE_BIT] && receive_irq_en) |=> irq)
      else $error("enabled receive flag did not interrupt");

   // Receive flag with its enable clear never contributes alone
   chk_receive_block: assert property (
      (flags[`RECEIVE_BIT] && !receive_irq_en && ((src_enabled & 6'h1F) == 6'h00))
      |=> !irq)
      else $error("masked receive source raised irq");

   // Serial port flag with its enable clear never contributes alone
   chk_serial_block: assert property (
      (flags[`SERIAL_BIT] && !sync_serial_irq_en && ((src_enabled & 6'h37) == 6'h00))
      |=> !irq)
      else $error("masked serial port source raised irq");

   // Capture/compare flag with its enable clear never contributes alone
   chk_capcmp_block: assert property (
      (flags[`CAPCMP_BIT] && !capture_compare_irq_en && ((src_enabled & 6'h3B) == 6'h00))
      |=> !irq)
      else $error("masked capture/compare source raised irq");

   // Period match flag with its enable clear never contributes alone
   chk_period_block: assert property (
      (flags[`PERIOD_BIT] && !period_match_irq_en && ((src_enabled & 6'h3D) == 6'h00))
      |=> !irq)
      else $error("masked period match source raised irq");

   // Overflow flag with its enable clear never contributes alone
   chk_overflow_block: assert property (
      (flags[`OVERFLOW_BIT] && !wide_timer_overflow_irq_en
       && ((src_enabled & 6'h3E) == 6'h00)) |=> !irq)
      else $error("masked overflow source raised irq");

   // A closed global enable keeps the output low one cycle later
   chk_global_gate: assert property (
      !global_irq_enable |=> !irq)
      else $error("irq raised while global enable was clear");

   // An implemented event sets its flag on the next edge, enables aside
   chk_flag_sets: assert property (
      ((ev_vec & flag_impl) != 6'h00) |=> ((flags & $past(ev_vec & flag_impl))
       == $past(ev_vec & flag_impl)))
      else $error("event did not set its flag");

   // Mask reads zero and the gates are not both open at the first edge after reset
   chk_reset_clear: assert property (
      !$past(hresetn) |-> (peripheral_irq_mask_reg == `MASK_RESET && !gates_open))
      else $error("enables not cleared by reset");

   // Variant without USART never holds bits 5:4
   chk_usart_absent: assert property (
      !has_usart |-> (peripheral_irq_mask_reg[5:4] == 2'h0 && flags[5:4] == 2'h0))
      else $error("unimplemented bits 5:4 became set");

   // A read holds off the bus for exactly one cycle
   chk_read_wait: assert property (
      take_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state is not one cycle");

   // Writes are taken with no wait state
   chk_write_no_wait: assert property (
      take_wr |=> hreadyout)
      else $error("write address phase was held off");

   // Every response is OKAY; there is nothing to refuse
   chk_resp_okay: assert property (
      !hresp)
      else $error("slave response was not OKAY");

   // Only the low byte lane ever carries read data
   chk_rdata_upper: assert property (
      hrdata[31:8] == 24'h000000)
      else $error("upper read data lanes not zero");

   // Read data leave a flop loaded in the wait cycle
   chk_rdata_loaded: assert property (
      rd.valid |=> (hrdata == {24'h000000, $past(rd_data)}))
      else $error("read data not loaded in the wait cycle");

   // Read data hold until the next read completes
   chk_rdata_hold: assert property (
      !rd.valid |=> $stable(hrdata))
      else $error("read data changed without a read");

   // A mask write lands whole, less the bits the variant lacks
   chk_mask_write: assert property (
      wr_mask |=> (peripheral_irq_mask_reg == $past(wr.data & mask_impl)))
      else $error("mask write did not land");

   // The mask changes only by a write to its own offset
   chk_mask_hold: assert property (
      !wr_mask |=> $stable(peripheral_irq_mask_reg))
      else $error("mask changed without a write");

   // A control write sets both gates from bits 7 and 6
   chk_ctrl_write: assert property (
      wr_ctrl |=> ({global_irq_enable, peripheral_group_enable}
       == $past(wr.data[`GLOBAL_EN_BIT:`GROUP_EN_BIT])))
      else $error("control write did not land");

   // The gates change only by a write to the control offset
   chk_ctrl_hold: assert property (
      !wr_ctrl |=> $stable({global_irq_enable, peripheral_group_enable}))
      else $error("gates changed without a write");

   // Writing one clears a flag that sees no event in that cycle
   chk_flag_clear: assert property (
      ((flag_clear & ~ev_vec) != 6'h00)
      |=> ((flags & $past(flag_clear & ~ev_vec)) == 6'h00))
      else $error("written flag did not clear");

   // A set flag stays set until it is written with one
   chk_flag_hold: assert property (
      ((flags & ~flag_clear) != 6'h00) |=> ((flags & $past(flags & ~flag_clear))
       == $past(flags & ~flag_clear)))
      else $error("flag dropped without a clear");

   // A flag rises only after an event of its own source
   chk_flag_cause: assert property (
      1'b1 |=> ((flags & ~$past(flags | ev_vec)) == 6'h00))
      else $error("flag set without an event");

endmodule

// [tb/peripheral_irq_enable_mask_tb.sv]
// Self-checking bench for the peripheral interrupt enable mask, both variants side by side
`timescale 1ns/100ps
`include "irq_mask_params.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module peripheral_irq_enable_mask_tb;
   import irq_mask_pkg::*;
   logic hclk, hresetn, hsel, hwrite;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, rdata0, rdata1, seed;
   logic rdy0, rdy1, resp0, resp1, irq0, irq1;
   src_vec_t src;
   int err_total, n_tests;
   // Reference state: index 0 is the USART variant, 1 the plain one
   logic [1:0] ctrl_m;
   logic [7:0] mask_m [2];
   logic [5:0] flag_m [2];

   // Both variants see the same bus; each slave paces its own hready
   peripheral_irq_enable_mask #(.has_usart(1'b1)) DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(rdy0), .hwdata(hwdata), .hreadyout(rdy0), .hresp(resp0), .hrdata(rdata0),
      .irq_sources(src), .irq(irq0));
   peripheral_irq_enable_mask #(.has_usart(1'b0)) DUT_plain (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(rdy1), .hwdata(hwdata), .hreadyout(rdy1), .hresp(resp1), .hrdata(rdata1),
      .irq_sources(src), .irq(irq1));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Interrupt needs global and group gates plus an enabled, set flag
   function automatic logic exp_irq(input int v);
      return ctrl_m[1] & ctrl_m[0] & (|(flag_m[v] & mask_m[v][5:0]));
   endfunction

   task automatic end_of_test;
      if (err_total == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Bounded wait for an edge at which hready is sampled high
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (rdy0 !== 1'b1 && n < 20);
      if (rdy0 !== 1'b1) begin
         err_total++;
         $display("mismatch hreadyout expected 1 seen %b", rdy0);
      end
   endtask

   // One single AHB-Lite transfer; read data is taken at the closing edge
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q0, output logic [31:0] q1);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q0 = rdata0;
      q1 = rdata1;
   endtask

   // Upper lanes carry noise, only the low byte should count
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q0, q1;
      seed = xs(seed);
      xfer(1'b1, {24'h000000, a}, {seed[31:8], d}, q0, q1);
      if (a == `CTRL_REG_OFS) ctrl_m = d[7:6];
      if (a == `MASK_REG_OFS) begin
         mask_m[0] = d & `MASK_IMPL_USART;
         mask_m[1] = d & `MASK_IMPL_PLAIN;
      end
      if (a == `FLAG_REG_OFS) begin
         flag_m[0] = flag_m[0] & ~d[5:0];
         flag_m[1] = flag_m[1] & ~d[5:0];
      end
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e0, input logic [7:0] e1);
      logic [31:0] q0, q1;
      xfer(1'b0, a, 32'h00000000, q0, q1);
      `CHK("rdata usart", {24'h000000, e0}, q0)
      `CHK("rdata plain", {24'h000000, e1}, q1)
      `CHK("hresp", 2'b00, {resp0, resp1})
   endtask

   // One-cycle event pulse; unimplemented sources must not latch
   task automatic pulse(input src_vec_t v);
      src <= v;
      @(posedge hclk);
      src <= '0;
      flag_m[0] = flag_m[0] | v;
      flag_m[1] = flag_m[1] | (v & `FLAG_IMPL_PLAIN);
   endtask

   // irq trails its cause by one registered stage
   task automatic chk_irq;
      repeat (2) @(posedge hclk);
      `CHK("irq usart", exp_irq(0), irq0)
      `CHK("irq plain", exp_irq(1), irq1)
   endtask

   task automatic rd_all;
      rd_chk(`MASK_REG_OFS, mask_m[0], mask_m[1]);
      rd_chk(`FLAG_REG_OFS, {2'b00, flag_m[0]}, {2'b00, flag_m[1]});
      rd_chk(`CTRL_REG_OFS, {ctrl_m, 6'h00}, {ctrl_m, 6'h00});
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // Cuts a hang short well beyond the expected run length
   initial begin
      #200000;
      err_total++;
      end_of_test();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      src = '0;
      seed = 32'hCA92FCE7;
      err_total = 0;
      n_tests = 0;
      ctrl_m = 2'h0;
      mask_m = '{8'h00, 8'h00};
      flag_m = '{6'h00, 6'h00};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_all();
      rd_chk(32'h00000100, 8'h00, 8'h00);
      rd_chk(32'h00000008, 8'h00, 8'h00);
      // Each enable bit alone, against every source in turn
      wr_reg(`CTRL_REG_OFS, 8'hC0);
      for (int i = 0; i < 6; i++) begin
         wr_reg(`MASK_REG_OFS, 8'h01 << i);
         for (int j = 0; j < 6; j++) begin
            pulse(src_vec_t'(6'h01 << j));
            chk_irq();
            wr_reg(`FLAG_REG_OFS, 8'h3F);
            chk_irq();
         end
      end
      // An event in the clearing data phase keeps its flag: the set wins
      fork
         wr_reg(`FLAG_REG_OFS, 8'h3F);
         begin
            @(posedge hclk);
            pulse(src_vec_t'(6'h01));
         end
      join
      flag_m = '{6'h01, 6'h01};
      chk_irq();
      rd_all();
      // Group and global gates each block on their own; flags still latch
      wr_reg(`MASK_REG_OFS, 8'h3F);
      wr_reg(`CTRL_REG_OFS, 8'h80);
      pulse(src_vec_t'(6'h3F));
      chk_irq();
      rd_all();
      wr_reg(`CTRL_REG_OFS, 8'h40);
      chk_irq();
      wr_reg(`CTRL_REG_OFS, 8'hC0);
      chk_irq();
      // Random gates, masks, events and partial clears
      for (int k = 0; k < 40; k++) begin
         seed = xs(seed);
         wr_reg(`CTRL_REG_OFS, seed[7:0]);
         wr_reg(`MASK_REG_OFS, seed[15:8]);
         pulse(src_vec_t'(seed[21:16]));
         chk_irq();
         rd_all();
         wr_reg(`FLAG_REG_OFS, seed[31:24]);
         chk_irq();
      end
      end_of_test();
   end
endmodule
